// *** pkg/dio_pkg.sv ***
// Purpose: Shared constants and types for the direct I/O request descriptor block.
// Assumes: One 250 MHz clock; registers reached over APB with 32-bit data.
// Notes: Word layouts of the descriptor sets and the header carrier live here.
package dio_pkg;

  // Clock rate and response timeout.
  localparam int CLK_MHZ = 250;
  localparam int RESP_TIMEOUT_US = 100; // Time allowed for a response to a non-posted request.
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_US * CLK_MHZ;

  // Descriptor set geometry.
  localparam int NUM_SETS = 4;
  localparam int WORDS_PER_SET = 7;
  localparam logic [11:0] SET0_BASE = 12'h400;
  localparam logic [11:0] SET_STRIDE = 12'h020;
  localparam logic [11:0] SET_LAST_END = 12'h478;

  // Word indices inside one set (byte offset is four times the index).
  localparam logic [2:0] W_ADDR_MSB = 3'h0;
  localparam logic [2:0] W_ADDR_LSB = 3'h1;
  localparam logic [2:0] W_LOCAL_ADDR = 3'h2;
  localparam logic [2:0] W_BYTE_COUNT = 3'h3;
  localparam logic [2:0] W_ROUTE = 3'h4;
  localparam logic [2:0] W_COMMAND = 3'h5;
  localparam logic [2:0] W_STATUS = 3'h6;

  // Field positions in the route word.
  localparam int DEST_ID_LSB = 0;
  localparam int ID_WIDTH_LSB = 16;
  localparam int XAMBS_LSB = 18;
  localparam int PRIO_LSB = 20;
  // Field positions in the status word, then the byte count field width and the full-page byte count.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CODE_LSB = 1;
  localparam int BYTE_COUNT_W = 12;
  localparam logic [12:0] FULL_PAGE_BYTES = 13'h1000;

  // Transaction type codes: FT_ codes are the upper nibble of the packet type, TR_NWRITE is a lower-nibble code.
  localparam logic [3:0] FT_NREAD = 4'h2;
  localparam logic [3:0] FT_WRITE = 4'h5;
  localparam logic [3:0] FT_SWRITE = 4'h6;
  localparam logic [3:0] FT_MAINT = 4'h8;
  localparam logic [3:0] TR_NWRITE = 4'h4;

  // Transport size encodings.
  localparam logic [1:0] ID_WIDTH_8 = 2'h0;
  localparam logic [1:0] ID_WIDTH_16 = 2'h1;

  // Completion codes.
  localparam logic [2:0] CC_OK = 3'h0;
  localparam logic [2:0] CC_TIMEOUT = 3'h1;
  localparam logic [2:0] CC_XOFF = 3'h2;
  localparam logic [2:0] CC_RESP_ERR = 3'h3;
  localparam logic [2:0] CC_BAD_PROG = 3'h4;

  // Per-set sequencing states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b100
  } dio_state_e;

  // Outgoing request header fields.
  typedef struct packed {
    logic [3:0] ftype;
    logic [3:0] ttype;
    logic [1:0] tt;
    logic [1:0] prio;
    logic [1:0] xambs;
    logic [15:0] dest_id;
    logic [7:0] tid;
    logic [31:0] ext_addr;
    logic [31:0] addr;
    logic [3:0] size;
    logic wdptr;
  } dio_hdr_s;

  // Header plus the local side of the transfer, which never enters the header.
  typedef struct packed {
    dio_hdr_s hdr;
    logic [31:0] local_addr;
    logic [12:0] byte_count;
  } dio_req_s;

  // Completion report from the link logic.
  typedef struct packed {
    logic [7:0] tid;
    logic err;
  } dio_resp_s;

endpackage : dio_pkg

// *** core/dio_request_unit.sv ***
// Purpose: Outbound direct I/O request unit; four descriptor sets launch load/store requests.
// Assumes: APB slave with no wait states; link logic on the same clock takes requests by valid/ready.
// Notes: Posted requests complete when loaded into the output register toward the link; non-posted ones wait for a response.
//
// Overview of operation
// RULE1 - Writing the command word launches one request built from the descriptor set.
// RULE2 - Hardware assigns each request's transaction ID from its own counter.
// RULE3 - Four sets of seven words at 0x400, stride 0x20, first ending 0x418.
// RULE4 - Types 2, 5, 6 carry the upper address word as extended address.
// RULE5 - Types 2, 5, 6 get doubleword-aligned address plus size and word pointer.
// RULE6 - Type 8 uses a 24-bit config offset aligned with the byte count.
// RULE7 - Software writes the two low config offset bits as zero.
// RULE8 - The local byte address only steers payload, never enters the header.
// RULE9 - Byte count zero means 4KB; otherwise exactly that many bytes.
// RULE10 - Software keeps maintenance byte counts at four bytes or fewer.
// RULE11 - ID width select 00 gives 8-bit IDs, 01 gives 16-bit; others reserved.
// RULE12 - Descriptor priority 0 to 3 is copied into the header prio field.
// RULE13 - Software avoids sending requests at priority 3.
// RULE14 - Descriptor xambs is copied into the header xambs field.
// RULE15 - Descriptor destination ID is copied into the header destination field.
// RULE16 - Software fills all descriptor words before writing the command word.
// RULE17 - Packet type upper nibble is ftype; lower nibble is trans for 2, 5, 8.
// RULE18 - Busy rises the cycle after the command write; set locked while busy.
// RULE19 - A 3-bit completion code is valid when busy clears.
// RULE20 - A reserved ID width select is not sent; reports invalid programming.
`timescale 1ns/100ps

module dio_request_unit #(
  parameter int TIMEOUT_CYCLES = dio_pkg::RESP_TIMEOUT_CYC,
  parameter int TID_W = 8
) (
  input wire logic clk_i, // 250 MHz clock.
  input wire logic reset_n_i, // Asynchronous active-low reset.
  input wire logic psel_i, // APB select.
  input wire logic penable_i, // APB access phase.
  input wire logic pwrite_i, // APB direction, high for write.
  input wire logic [11:0] paddr_i, // APB byte address.
  input wire logic [31:0] pwdata_i, // APB write data.
  output logic [31:0] prdata_o, // APB read data.
  output logic pready_o, // APB ready.
  output logic pslverr_o, // APB error.
  output logic req_valid_o, // Request available to the link.
  output dio_pkg::dio_req_s req_o, // Request header and local transfer details.
  input wire logic req_ready_i, // Link takes the request.
  input wire logic xoff_i, // Link flow control blocks new requests.
  input wire logic resp_valid_i, // Response for a non-posted request.
  input wire dio_pkg::dio_resp_s resp_i // Response tag and error flag.
);

  localparam int N = dio_pkg::NUM_SETS;
  localparam logic [31:0] TIMEOUT_LAST = 32'(TIMEOUT_CYCLES - 1);

  // Descriptor storage, command type, status and sequencing per set.
  logic [31:0] desc [N][5];
  logic [7:0] cmd_type [N];
  logic busy [N];
  logic [2:0] code [N];
  logic [TID_W-1:0] set_tid [N];
  logic [31:0] timer [N];
  dio_pkg::dio_state_e state [N];
  logic [TID_W-1:0] tid_ctr;

  // Address decode of the current APB transfer.
  logic in_window;
  logic [1:0] sel_set;
  logic [2:0] sel_word;
  logic addr_ok;
  logic acc_edge;
  logic wr_fire;
  logic cmd_fire;

  // Arbitration between sets waiting to send.
  logic grant_any;
  logic [1:0] grant_idx;
  logic out_free;
  dio_pkg::dio_req_s next_req;

  // Size and word pointer for a transfer of n bytes starting at offset off within a doubleword.
  function automatic logic [4:0] size_enc(input logic [2:0] off, input logic [12:0] n);
    logic [4:0] r;
    r = {1'b1, 4'hf};
    if (n == 13'h0001) begin
      r = {off[2], 2'b00, off[1:0]};
    end else if (n == 13'h0002) begin
      r = {off[2], 2'b01, off[1], 1'b0};
    end else if (n == 13'h0003) begin
      r = {off[2], (off[1:0] == 2'b00) ? 4'h5 : 4'h7};
    end else if (n == 13'h0004) begin
      r = {off[2], 4'h8};
    end else if (n <= 13'h0007) begin
      r = {off[2], (n == 13'h0005) ? 4'h7 : ((n == 13'h0006) ? 4'h9 : 4'ha)};
    end else if (n == 13'h0008) begin
      r = {1'b0, 4'hb};
    end else if (n <= 13'h0010) begin
      r = {1'b1, 4'hb};
    end else if (n <= 13'h0020) begin
      r = {1'b0, 4'hc};
    end else if (n <= 13'h0040) begin
      r = {1'b1, 4'hc};
    end else if (n <= 13'h0080) begin
      r = {1'b1, 4'hd};
    end
    return r;
  endfunction : size_enc

  // Builds one request from a descriptor set.
  function automatic dio_pkg::dio_req_s build_req(input logic [31:0] w_msb, input logic [31:0] w_lsb,
                                                  input logic [31:0] w_local, input logic [31:0] w_cnt,
                                                  input logic [31:0] w_route, input logic [7:0] ptype,
                                                  input logic [TID_W-1:0] tid);
    dio_pkg::dio_req_s r;
    logic [12:0] n;
    logic [4:0] sz;
    r = '0;
    // Zero count stands for a whole 4KB page.
    n = (w_cnt[dio_pkg::BYTE_COUNT_W-1:0] == 12'h000) ? dio_pkg::FULL_PAGE_BYTES
        : {1'b0, w_cnt[dio_pkg::BYTE_COUNT_W-1:0]}; // see RULE9
    sz = size_enc(w_lsb[2:0], n); // see RULE5
    r.hdr.ftype = ptype[7:4]; // see RULE17
    if (ptype[7:4] == dio_pkg::FT_NREAD || ptype[7:4] == dio_pkg::FT_WRITE || ptype[7:4] == dio_pkg::FT_MAINT) begin
      r.hdr.ttype = ptype[3:0]; // see RULE17
    end
    r.hdr.tt = w_route[dio_pkg::ID_WIDTH_LSB +: 2]; // see RULE11
    r.hdr.prio = w_route[dio_pkg::PRIO_LSB +: 2]; // see RULE12
    r.hdr.xambs = w_route[dio_pkg::XAMBS_LSB +: 2]; // see RULE14
    r.hdr.dest_id = w_route[dio_pkg::DEST_ID_LSB +: 16]; // see RULE15
    r.hdr.tid = 8'(tid); // see RULE2
    if (ptype[7:4] == dio_pkg::FT_MAINT) begin
      // Only 24 offset bits travel; the low three are dropped by doubleword alignment.
      r.hdr.addr = {8'h00, w_lsb[23:3], 3'b000}; // see RULE6
    end else begin
      r.hdr.ext_addr = w_msb; // see RULE4
      r.hdr.addr = {w_lsb[31:3], 3'b000}; // see RULE5
    end
    r.hdr.size = sz[3:0]; // see RULE5
    r.hdr.wdptr = sz[4]; // see RULE5
    // The local address rides beside the header for the payload engine only.
    r.local_addr = w_local; // see RULE8
    r.byte_count = n;
    return r;
  endfunction : build_req

  // Decode: sets live at 0x400 + 0x20 * set, seven words each.
  always_comb begin
    in_window = (paddr_i >= dio_pkg::SET0_BASE) && (paddr_i <= dio_pkg::SET_LAST_END); // see RULE3
    sel_set = paddr_i[6:5];
    sel_word = paddr_i[4:2];
    addr_ok = in_window && (paddr_i[1:0] == 2'b00) && (sel_word < 3'(dio_pkg::WORDS_PER_SET)); // see RULE3
    acc_edge = psel_i && penable_i && pready_o;
    // A locked set ignores writes; status stays readable.
    wr_fire = acc_edge && pwrite_i && addr_ok && !busy[sel_set] && (sel_word != dio_pkg::W_STATUS); // see RULE18
    cmd_fire = wr_fire && (sel_word == dio_pkg::W_COMMAND); // see RULE1
  end

  // APB answer is registered in the setup cycle, so every access takes exactly one access cycle.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i &&
                   (!addr_ok || (pwrite_i && busy[sel_set] && sel_word != dio_pkg::W_STATUS));
      prdata_o <= 32'h0000_0000;
      if (psel_i && !penable_i && !pwrite_i && addr_ok) begin
        case (sel_word)
          dio_pkg::W_COMMAND: begin
            prdata_o <= {24'h00_0000, cmd_type[sel_set]};
          end
          dio_pkg::W_STATUS: begin
            prdata_o <= {28'h000_0000, code[sel_set], busy[sel_set]}; // see RULE19
          end
          default: begin
            prdata_o <= desc[sel_set][sel_word];
          end
        endcase
      end
    end
  end

  // Descriptor words and command type are stored on the access edge of a write.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int s = 0; s < N; s++) begin
        cmd_type[s] <= 8'h00;
        for (int w = 0; w < 5; w++) begin
          desc[s][w] <= 32'h0000_0000;
        end
      end
    end else if (wr_fire) begin
      if (sel_word == dio_pkg::W_COMMAND) begin
        cmd_type[sel_set] <= pwdata_i[7:0];
      end else begin
        desc[sel_set][sel_word] <= pwdata_i;
      end
    end
  end

  // Fixed priority: the lowest numbered set that is ready to send and not blocked wins.
  // A set with a reserved id width or an unsupported type never competes, so it cannot leak onto the link.
  always_comb begin
    grant_any = 1'b0;
    grant_idx = 2'h0;
    for (int s = N - 1; s >= 0; s--) begin
      if (state[s] == dio_pkg::ST_SEND && !xoff_i &&
          !desc[s][dio_pkg::W_ROUTE][dio_pkg::ID_WIDTH_LSB + 1] && // see RULE20
          cmd_type[s][7:4] inside {dio_pkg::FT_NREAD, dio_pkg::FT_WRITE, dio_pkg::FT_SWRITE, dio_pkg::FT_MAINT}) begin
        grant_any = 1'b1;
        grant_idx = 2'(s);
      end
    end
    out_free = !req_valid_o || req_ready_i;
    next_req = build_req(desc[grant_idx][0], desc[grant_idx][1], desc[grant_idx][2], desc[grant_idx][3],
                         desc[grant_idx][4], cmd_type[grant_idx], tid_ctr);
  end

  // Output register toward the link; held until the link takes it.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_valid_o <= 1'b0;
      req_o <= '0;
    end else if (out_free) begin
      req_valid_o <= grant_any;
      if (grant_any) begin
        req_o <= next_req; // see RULE1
      end
    end
  end

  // Transaction ID counter advances once per launched request.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tid_ctr <= '0;
    end else if (out_free && grant_any) begin
      tid_ctr <= tid_ctr + 1'b1; // see RULE2
    end
  end

  // Per-set sequencing: launch, wait for acceptance or response, then report a completion code.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int s = 0; s < N; s++) begin
        state[s] <= dio_pkg::ST_IDLE;
        busy[s] <= 1'b0;
        code[s] <= dio_pkg::CC_OK;
        set_tid[s] <= '0;
        timer[s] <= 32'h0000_0000;
      end
    end else begin
      for (int s = 0; s < N; s++) begin
        case (state[s])
          dio_pkg::ST_IDLE: begin
            if (cmd_fire && sel_set == 2'(s)) begin
              busy[s] <= 1'b1; // see RULE18
              state[s] <= dio_pkg::ST_SEND;
            end
          end
          dio_pkg::ST_SEND: begin
            timer[s] <= 32'h0000_0000;
            if (desc[s][dio_pkg::W_ROUTE][dio_pkg::ID_WIDTH_LSB +: 2] != dio_pkg::ID_WIDTH_8 &&
                desc[s][dio_pkg::W_ROUTE][dio_pkg::ID_WIDTH_LSB +: 2] != dio_pkg::ID_WIDTH_16) begin
              // Reserved transport size: nothing goes out.
              code[s] <= dio_pkg::CC_BAD_PROG; // see RULE20
              busy[s] <= 1'b0;
              state[s] <= dio_pkg::ST_IDLE;
            end else if (cmd_type[s][7:4] != dio_pkg::FT_NREAD && cmd_type[s][7:4] != dio_pkg::FT_WRITE &&
                         cmd_type[s][7:4] != dio_pkg::FT_SWRITE && cmd_type[s][7:4] != dio_pkg::FT_MAINT) begin
              code[s] <= dio_pkg::CC_BAD_PROG;
              busy[s] <= 1'b0;
              state[s] <= dio_pkg::ST_IDLE;
            end else if (xoff_i) begin
              code[s] <= dio_pkg::CC_XOFF; // see RULE19
              busy[s] <= 1'b0;
              state[s] <= dio_pkg::ST_IDLE;
            end else if (out_free && grant_idx == 2'(s)) begin
              set_tid[s] <= tid_ctr;
              // Posted writes need no answer; they finish once handed to the link.
              if (cmd_type[s][7:4] == dio_pkg::FT_SWRITE ||
                  (cmd_type[s][7:4] == dio_pkg::FT_WRITE && cmd_type[s][3:0] == dio_pkg::TR_NWRITE)) begin
                code[s] <= dio_pkg::CC_OK;
                busy[s] <= 1'b0;
                state[s] <= dio_pkg::ST_IDLE;
              end else begin
                state[s] <= dio_pkg::ST_WAIT;
              end
            end
          end
          dio_pkg::ST_WAIT: begin
            timer[s] <= timer[s] + 32'h0000_0001;
            if (resp_valid_i && resp_i.tid == 8'(set_tid[s])) begin
              code[s] <= resp_i.err ? dio_pkg::CC_RESP_ERR : dio_pkg::CC_OK; // see RULE19
              busy[s] <= 1'b0;
              state[s] <= dio_pkg::ST_IDLE;
            end else if (timer[s] >= TIMEOUT_LAST) begin
              code[s] <= dio_pkg::CC_TIMEOUT; // see RULE19
              busy[s] <= 1'b0;
              state[s] <= dio_pkg::ST_IDLE;
            end
          end
          default: begin
            busy[s] <= 1'b0;
            state[s] <= dio_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule : dio_request_unit

// *** testbench/dio_request_unit_sva.sv ***
// Purpose: Port-level checks of the direct I/O request unit.
// Assumes: One clock domain; reset_n_i is asynchronous, active low.
// Notes: Only the top module's ports are watched.
`timescale 1ns/100ps
module dio_request_unit_sva (
  input wire logic clk_i, // Clock.
  input wire logic reset_n_i, // Reset, active low.
  input wire logic psel_i, // APB select.
  input wire logic penable_i, // APB access phase.
  input wire logic pwrite_i, // APB direction.
  input wire logic [11:0] paddr_i, // APB address.
  input wire logic [31:0] pwdata_i, // APB write data.
  input wire logic [31:0] prdata_o, // APB read data.
  input wire logic pready_o, // APB ready.
  input wire logic pslverr_o, // APB error.
  input wire logic req_valid_o, // Request valid.
  input wire dio_pkg::dio_req_s req_o, // Request.
  input wire logic req_ready_i, // Request taken.
  input wire logic xoff_i, // Flow-control block.
  input wire logic resp_valid_i, // Response pulse.
  input wire dio_pkg::dio_resp_s resp_i // Response.
);
  logic seen;
  logic [7:0] last_tid;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_stall;
    req_valid_o && !req_ready_i;
  endsequence
  sequence s_take;
    req_valid_o && req_ready_i;
  endsequence
  // Remember the last tag handed over, so a skipped or repeated tag shows.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seen <= 1'b0;
      last_tid <= 8'h00;
    end else if (req_valid_o && req_ready_i) begin
      seen <= 1'b1;
      last_tid <= req_o.hdr.tid;
    end
  end
  a_ready_after_setup: assert property (s_setup |=> pready_o && penable_i)
    else $error("No ready after setup.");
  a_ready_single: assert property (pready_o |=> !pready_o) else $error("Ready held too long.");
  a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("Error without ready.");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0) else $error("Read data outside access.");
  a_req_hold: assert property (s_stall |=> req_valid_o && $stable(req_o))
    else $error("Request changed before taken.");
  a_tid_step: assert property (s_take |-> req_o.hdr.tid == (seen ? last_tid + 8'h01 : 8'h00))
    else $error("Tag not in sequence.");
  a_tt_legal: assert property (req_valid_o |-> req_o.hdr.tt inside {2'h0, 2'h1})
    else $error("Reserved id width sent.");
  a_ftype_legal: assert property (req_valid_o |-> req_o.hdr.ftype inside {4'h2, 4'h5, 4'h6, 4'h8})
    else $error("Unsupported type sent.");
  a_maint_addr: assert property (req_valid_o && req_o.hdr.ftype == dio_pkg::FT_MAINT |->
    req_o.hdr.ext_addr == 32'h0 && req_o.hdr.addr[31:24] == 8'h0 && req_o.hdr.addr[2:0] == 3'h0)
    else $error("Bad config offset.");
  a_addr_align: assert property (req_valid_o && req_o.hdr.ftype != dio_pkg::FT_MAINT |->
    req_o.hdr.addr[2:0] == 3'h0) else $error("Address not aligned.");
  a_count_range: assert property (req_valid_o |-> req_o.byte_count inside {[13'h1:13'h1000]})
    else $error("Byte count out of range.");
endmodule : dio_request_unit_sva
bind dio_request_unit dio_request_unit_sva u_sva (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .req_valid_o(req_valid_o), .req_o(req_o),
  .req_ready_i(req_ready_i), .xoff_i(xoff_i), .resp_valid_i(resp_valid_i), .resp_i(resp_i));

// *** testbench/dio_link_model.sv ***
// Purpose: Link-side partner that takes requests and answers non-posted ones.
// Assumes: Same clock as the unit; mode_i is {xoff, silent, err, slow}.
// Notes: Response lines toggle when idle so a stale value never looks valid.
`timescale 1ns/100ps
module dio_link_model (
  input wire logic clk_i, // Clock.
  input wire logic reset_n_i, // Reset, active low.
  input wire logic [3:0] mode_i, // Behaviour select.
  input wire logic req_valid_i, // Request offered.
  input wire dio_pkg::dio_req_s req_i, // Request.
  output logic req_ready_o, // Request taken.
  output logic xoff_o, // Flow-control block.
  output logic resp_valid_o, // Response pulse.
  output dio_pkg::dio_resp_s resp_o // Response.
);
  logic [3:0] wait_cnt;
  logic [1:0] rdy_cnt;
  logic np;
  // Reads, maintenance and acknowledged writes expect an answer.
  assign np = req_i.hdr.ftype inside {dio_pkg::FT_NREAD, dio_pkg::FT_MAINT} ||
    (req_i.hdr.ftype == dio_pkg::FT_WRITE && req_i.hdr.ttype != dio_pkg::TR_NWRITE);
  assign xoff_o = mode_i[3];
  // Slow mode makes the unit hold its request for three cycles.
  assign req_ready_o = req_valid_i && (!mode_i[0] || rdy_cnt == 2'h3);
  // The answer comes six cycles after the take, unless silent.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_cnt <= 4'h0;
      rdy_cnt <= 2'h0;
      resp_valid_o <= 1'b0;
      resp_o <= '0;
    end else begin
      rdy_cnt <= (req_valid_i && !req_ready_o) ? rdy_cnt + 2'h1 : 2'h0;
      resp_valid_o <= wait_cnt == 4'h1;
      resp_o <= (wait_cnt == 4'h1) ? {resp_o.tid, mode_i[1]} : ~resp_o;
      if (req_ready_o && np && !mode_i[2]) begin
        wait_cnt <= 4'h6;
        resp_o.tid <= ~req_i.hdr.tid;
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule : dio_link_model

// *** testbench/direct_io_request_descriptor_test.sv ***
// Purpose: Self-checking bench of the direct I/O request unit.
// Assumes: APB master and link partner on one 250 MHz clock.
// Notes: Drivers queue expectations; watchers compare when results appear.
`timescale 1ns/100ps
module direct_io_request_descriptor_test;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'hba09;
  logic pready, pslverr, req_valid, req_ready, xoff, resp_valid;
  logic [3:0] mode = 4'h0;
  logic [7:0] tid = 8'h00;
  logic [64:0] apb_x;
  logic [64:0] apb_q[$];
  dio_pkg::dio_req_s req;
  dio_pkg::dio_req_s req_q[$];
  dio_pkg::dio_resp_s resp;
  int errors = 0, comparisons = 0, cycles = 0;
  dio_request_unit #(.TIMEOUT_CYCLES(20)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .req_valid_o(req_valid), .req_o(req), .req_ready_i(req_ready),
    .xoff_i(xoff), .resp_valid_i(resp_valid), .resp_i(resp));
  dio_link_model link (.clk_i(clk_i), .reset_n_i(reset_n_i), .mode_i(mode), .req_valid_i(req_valid),
    .req_i(req), .req_ready_o(req_ready), .xoff_o(xoff), .resp_valid_o(resp_valid), .resp_o(resp));
  // Free-running clock, 4 ns period.
  initial forever #2 clk_i = ~clk_i;
  function automatic logic [31:0] nx(input logic [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx
  task automatic chk(input logic [159:0] g, input logic [159:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic print_verdict();
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // One APB transfer; an idle cycle follows so no signal is driven twice at one edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] e, input logic er, output logic [31:0] r);
    apb_q.push_back({m, e, er});
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  // Fill one set, launch it, check busy and refusal while busy for sent non-posted requests, and check the completion code.
  task automatic launch(input int s, input logic [7:0] pt, input logic [1:0] tt, input logic [11:0] cnt,
                        input logic [31:0] lsb, input logic [3:0] md, input logic [2:0] code);
    logic [11:0] b;
    logic [31:0] r, msb, loc, rt;
    logic np, sent;
    dio_pkg::dio_req_s e;
    int n;
    b = dio_pkg::SET0_BASE + dio_pkg::SET_STRIDE * 12'(s);
    lfsr = nx(lfsr);
    msb = lfsr;
    lfsr = nx(lfsr);
    loc = lfsr;
    lfsr = nx(lfsr);
    if (pt[7:4] != 4'h8) lsb = {lfsr[31:3], 3'h0};
    rt = {10'h0, (lfsr[21:20] == 2'h3) ? 2'h2 : lfsr[21:20], lfsr[19:18], tt, tt[0] ? lfsr[15:8] : 8'h0, lfsr[7:0]};
    np = pt[7:4] inside {4'h2, 4'h8} || pt == 8'h55;
    sent = code inside {dio_pkg::CC_OK, dio_pkg::CC_TIMEOUT, dio_pkg::CC_RESP_ERR};
    e = '0;
    e.hdr.ftype = pt[7:4];
    e.hdr.ttype = (pt[7:4] inside {4'h2, 4'h5, 4'h8}) ? pt[3:0] : 4'h0;
    {e.hdr.prio, e.hdr.xambs, e.hdr.tt, e.hdr.dest_id} = rt[21:0];
    e.hdr.tid = tid;
    e.hdr.ext_addr = (pt[7:4] == 4'h8) ? 32'h0 : msb;
    e.hdr.addr = (pt[7:4] == 4'h8) ? {8'h0, lsb[23:0]} : lsb;
    {e.hdr.size, e.hdr.wdptr} = (cnt == 12'h0) ? 5'h1f : (cnt == 12'h4) ? 5'h10 : 5'h16;
    e.local_addr = loc;
    e.byte_count = (cnt == 12'h0) ? dio_pkg::FULL_PAGE_BYTES : {1'b0, cnt};
    if (sent) begin
      req_q.push_back(e);
      tid = tid + 8'h01;
    end
    mode <= md;
    // Every descriptor word is written before the command word.
    apb(1, b, msb, 0, 0, 0, r);
    apb(1, b + 12'h04, lsb, 0, 0, 0, r);
    apb(1, b + 12'h08, loc, 0, 0, 0, r);
    apb(1, b + 12'h0c, {20'h0, cnt}, 0, 0, 0, r);
    apb(1, b + 12'h10, rt, 0, 0, 0, r);
    apb(1, b + 12'h14, {24'h0, pt}, 0, 0, 0, r);
    if (sent && np) begin
      apb(0, b + 12'h18, 0, 32'h1, 32'h1, 0, r);
      apb(1, b, 0, 0, 0, 1, r);
    end
    n = 0;
    do begin
      apb(0, b + 12'h18, 0, 0, 0, 0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 40);
    apb(0, b + 12'h18, 0, 32'hf, {28'h0, code, 1'b0}, 0, r);
  endtask : launch
  // Every APB answer is matched to the oldest queued expectation.
  always @(posedge clk_i) begin
    if (pready === 1'b1 && apb_q.size() > 0) begin
      apb_x = apb_q.pop_front();
      chk({prdata & apb_x[64:33], pslverr}, {apb_x[32:1], apb_x[0]});
    end
  end
  // Every request taken by the link must have been expected.
  always @(posedge clk_i) begin
    if (req_valid === 1'b1 && req_ready === 1'b1) begin
      chk(req_q.size() != 0, 1'b1);
      if (req_q.size() != 0) chk(req, req_q.pop_front());
    end
  end
  // A hang ends the run as a failure.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    logic [31:0] r;
    reset_n_i = 1'b0;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    for (int s = 0; s < 4; s++) begin
      apb(0, 12'h418 + 12'(s) * 12'h020, 0, 32'hf, 0, 0, r);
    end
    apb(1, 12'h418, 32'hffff_ffff, 0, 0, 0, r);
    apb(0, 12'h418, 0, 32'hf, 0, 0, r);
    apb(0, 12'h41c, 0, 0, 0, 1, r);
    apb(0, 12'h480, 0, 0, 0, 1, r);
    apb(0, 12'h3fc, 0, 0, 0, 1, r);
    apb(0, 12'h402, 0, 0, 0, 1, r);
    launch(0, 8'h24, 2'h1, 12'h008, 0, 4'h0, dio_pkg::CC_OK);
    launch(1, 8'h54, 2'h0, 12'h008, 0, 4'h1, dio_pkg::CC_OK);
    launch(2, 8'h55, 2'h1, 12'h008, 0, 4'h2, dio_pkg::CC_RESP_ERR);
    launch(3, 8'h60, 2'h0, 12'h000, 0, 4'h0, dio_pkg::CC_OK);
    launch(0, 8'h80, 2'h1, 12'h004, 32'hff12_3450, 4'h1, dio_pkg::CC_OK);
    launch(1, 8'h2c, 2'h0, 12'h008, 0, 4'h0, dio_pkg::CC_OK);
    launch(2, 8'h24, 2'h0, 12'h008, 0, 4'h4, dio_pkg::CC_TIMEOUT);
    launch(3, 8'h24, 2'h1, 12'h008, 0, 4'h8, dio_pkg::CC_XOFF);
    launch(0, 8'h24, 2'h2, 12'h008, 0, 4'h0, dio_pkg::CC_BAD_PROG);
    launch(1, 8'h24, 2'h3, 12'h008, 0, 4'h0, dio_pkg::CC_BAD_PROG);
    launch(2, 8'h70, 2'h0, 12'h008, 0, 4'h0, dio_pkg::CC_BAD_PROG);
    repeat (10) @(posedge clk_i);
    chk(req_q.size(), 0);
    print_verdict();
  end
endmodule : direct_io_request_descriptor_test
